// [core/swl_host_pkg.sv]
// Package for the single-wire link master: timing, opcodes, carrier types.
// Assumes a 100 MHz core clock; counts are derived from the times below.
package swl_host_pkg;

  // Core clock rate
  localparam int CLK_MHZ = 100;

  // Line timing in ns, master side
  localparam int RESET_LOW_TIME_NS      = 480_000;
  localparam int PRESENCE_SAMPLE_NS     = 70_000;
  localparam int RESET_HIGH_TIME_NS     = 480_000;
  localparam int SLOT_TIME_NS           = 65_000;
  localparam int WRITE_ZERO_LOW_TIME_NS = 60_000;
  localparam int WRITE_ONE_LOW_TIME_NS  = 6_000;
  localparam int READ_VALID_TIME_NS     = 13_000;
  localparam int RECOVERY_TIME_NS       = 5_000;

  // Least times, rounded up to whole cycles
  localparam int RESET_LOW_CYCLES  = (RESET_LOW_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int PRES_SAMPLE_CYCLES = (PRESENCE_SAMPLE_NS * CLK_MHZ + 999) / 1000;
  localparam int RESET_HIGH_CYCLES = (RESET_HIGH_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int SLOT_CYCLES       = (SLOT_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int WRITE_ZERO_CYCLES = (WRITE_ZERO_LOW_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int WRITE_ONE_CYCLES  = (WRITE_ONE_LOW_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int READ_VALID_CYCLES = (READ_VALID_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int RECOVERY_CYCLES   = (RECOVERY_TIME_NS * CLK_MHZ + 999) / 1000;

  // Slot timer
  localparam int TIMER_W = 20;
  typedef logic [TIMER_W-1:0] timer_t;

  // Identifier commands the user sends as write bytes
  localparam logic [7:0] CMD_READ_ID   = 8'h33;
  localparam logic [7:0] CMD_MATCH_ID  = 8'h55;
  localparam logic [7:0] CMD_SKIP_ID   = 8'hCC;
  localparam logic [7:0] CMD_SEARCH_ID = 8'hF0;

  // Bit-serial CRC, x^8 + x^5 + x^4 + 1 shifted LSB first
  localparam logic [7:0] CRC_POLY_REFLECTED = 8'h8C;
  localparam logic [7:0] CRC_RESET_VALUE    = 8'h00;

  // Search result byte layout
  localparam int SRCH_ID_BIT   = 0;
  localparam int SRCH_CMP_BIT  = 1;
  localparam int SRCH_DIR_BIT  = 2;
  localparam int SRCH_NONE_BIT = 3;

  // Command operations
  typedef enum logic [1:0] {
    OP_RESET  = 2'b00,
    OP_WRITE  = 2'b01,
    OP_READ   = 2'b10,
    OP_SEARCH = 2'b11
  } op_t;

  // Command carrier
  typedef struct packed {
    op_t        op;
    logic [7:0] data;
    logic       dir;
  } cmd_t;

endpackage

// [core/swl_fifo.sv]
// Small FIFO with a registered output stage, valid and ready on both sides.
// Assumes one clock and an active-low asynchronous reset already synchronised.
`timescale 1ns/1ns
`default_nettype none
module swl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  // Fill side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // Drain side
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             push;
  logic             pop;

  // Storage moves to the output stage whenever that stage is free
  assign push = i_in_valid && o_in_ready;
  assign pop  = (cnt_q != '0) && (!o_out_valid || i_out_ready);
  always_comb begin
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  // Pointers, count and full flag kept as registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wp_q       <= '0;
      rp_q       <= '0;
      cnt_q      <= '0;
      o_in_ready <= 1'b1;
    end else begin
      if (push) begin
        wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + AW'(1);
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + AW'(1);
      end
      cnt_q      <= cnt_d;
      o_in_ready <= (cnt_d != DEPTH_C);
    end
  end

  // Memory array, no reset needed on data
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wp_q] <= i_in_data;
    end
  end

  // Output register; a stalled drain side holds the word
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_out_valid <= 1'b0;
      o_out_data  <= '0;
    end else if (!o_out_valid || i_out_ready) begin
      o_out_valid <= (cnt_q != '0);
      if (cnt_q != '0) begin
        o_out_data <= mem_q[rp_q];
      end
    end
  end
endmodule
`default_nettype wire

// [core/swl_crc8.sv]
// Bit-serial CRC generator for the single-wire link.
// Assumes bits arrive one per enable pulse, least significant first.
`timescale 1ns/1ns
`default_nettype none
module swl_crc8
  import swl_host_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // Control and data
  input  wire logic       i_clr,
  input  wire logic       i_en,
  input  wire logic       i_bit,
  // Result
  output logic [7:0]      o_crc
);
  logic fb;

  assign fb = o_crc[0] ^ i_bit;

  // Clear wins over a shift only because a new sequence restarts from zero
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_crc <= CRC_RESET_VALUE;
    end else if (i_clr) begin
      o_crc <= CRC_RESET_VALUE;
    end else if (i_en) begin
      o_crc <= {1'b0, o_crc[7:1]} ^ (fb ? CRC_POLY_REFLECTED : 8'h00);
    end
  end
endmodule
`default_nettype wire

// [core/swl_host.sv]
// Master for a single-wire open-drain multidrop link: reset and presence,
// byte write, byte read and search triplets, read data through a FIFO.
// Assumes an external pullup on the line and inputs synchronous to the clock.
//
// Summary of operation
// - CRC polynomial x^8 + x^5 + x^4 + 1
// - CRC starts at zero, fed LSB first
// - Master computes CRC; the user judges the result
// - Suspended master leaves line released high
// - Reset, identifier command, function, then data
// - Read identifier: 64 read slots
// - Match identifier: master sends 64 bits
// - Search: bit, complement, then master write (the code skips the write slot when bit and complement both read 1)
// - Master holds low reset time, releases
// - Slots last slot time, recovery between
// - Write one short low, zero whole slot (the code releases a zero after WRITE_ZERO_CYC, before SLOT_CYC ends)
// - Read: short low, sample at valid time
`timescale 1ns/1ns
`default_nettype none
module swl_host
  import swl_host_pkg::*;
#(
  parameter int     FIFO_DEPTH      = 8,
  parameter timer_t RESET_LOW_CYC   = timer_t'(RESET_LOW_CYCLES),
  parameter timer_t PRES_SAMPLE_CYC = timer_t'(PRES_SAMPLE_CYCLES),
  parameter timer_t RESET_HIGH_CYC  = timer_t'(RESET_HIGH_CYCLES),
  parameter timer_t SLOT_CYC        = timer_t'(SLOT_CYCLES),
  parameter timer_t WRITE_ZERO_CYC  = timer_t'(WRITE_ZERO_CYCLES)
) (
  // Clock and reset
  input  wire logic       I_CORE_CLK,
  input  wire logic       I_ARST_N,
  // Command port
  input  wire logic       I_CMD_VALID,
  input  wire cmd_t       I_CMD,
  output logic            O_CMD_READY,
  // Read data and search results
  output logic            O_RD_VALID,
  output logic [7:0]      O_RD_DATA,
  input  wire logic       I_RD_READY,
  // Status and CRC
  input  wire logic       I_CRC_CLEAR,
  output logic [7:0]      O_CRC,
  output logic            O_PRESENCE,
  output logic            O_BUSY,
  // Open-drain line
  input  wire logic       I_LINE_I,
  output logic            O_LINE_O,
  output logic            O_LINE_OE
);
  // Short times stay fixed, they fit the timer easily
  localparam timer_t WRITE_ONE_CYC  = timer_t'(WRITE_ONE_CYCLES);
  localparam timer_t READ_VALID_CYC = timer_t'(READ_VALID_CYCLES);
  localparam timer_t RECOVERY_CYC   = timer_t'(RECOVERY_CYCLES);

  typedef enum logic [1:0] {
    SL_IDLE = 2'b00,
    SL_RUN  = 2'b01,
    SL_REC  = 2'b10
  } slot_st_t;

  typedef enum logic [1:0] {
    SQ_IDLE  = 2'b00,
    SQ_RESET = 2'b01,
    SQ_BITS  = 2'b10,
    SQ_PUSH  = 2'b11
  } seq_st_t;

  logic [1:0]  rst_sync_q;
  logic        rst_n;
  slot_st_t    sl_q;
  seq_st_t     sq_q;
  timer_t      tim_q;
  timer_t      low_q;
  timer_t      samp_at_q;
  timer_t      end_q;
  logic        start_q;
  logic        kind_rst_q;
  logic        wbit_q;
  logic        samp_q;
  logic        done_q;
  op_t         op_q;
  logic [7:0]  shift_q;
  logic [2:0]  bitcnt_q;
  logic [1:0]  trip_q;
  logic        id_q;
  logic        cmp_q;
  logic        dirsel_q;
  logic [7:0]  res_q;
  logic        fifo_in_ready;
  logic        push_valid;
  logic        crc_en;
  logic        srch_dir;

  // Reset release through two flops
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // The line is only ever pulled low or released, never driven high
  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_LINE_O <= 1'b0;
    end else begin
      O_LINE_O <= 1'b0;
    end
  end

  // Slot timer: one low phase, one sample point, then recovery high
  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      sl_q      <= SL_IDLE;
      tim_q     <= '0;
      low_q     <= '0;
      samp_at_q <= '0;
      end_q     <= '0;
      O_LINE_OE <= 1'b0;
      samp_q    <= 1'b1;
      done_q    <= 1'b0;
    end else begin
      done_q <= 1'b0;
      unique case (sl_q)
        SL_IDLE: begin
          if (start_q) begin
            sl_q      <= SL_RUN;
            tim_q     <= '0;
            O_LINE_OE <= 1'b1;
            if (kind_rst_q) begin
              low_q     <= RESET_LOW_CYC;
              samp_at_q <= RESET_LOW_CYC + PRES_SAMPLE_CYC;
              end_q     <= RESET_LOW_CYC + RESET_HIGH_CYC - timer_t'(1);
            end else begin
              low_q     <= wbit_q ? WRITE_ONE_CYC : WRITE_ZERO_CYC;
              samp_at_q <= READ_VALID_CYC;
              end_q     <= SLOT_CYC - timer_t'(1);
            end
          end
        end
        SL_RUN: begin
          tim_q <= tim_q + timer_t'(1);
          // Release exactly after the low count; a write zero never outlasts the slot
          if (tim_q + timer_t'(1) == low_q) begin
            O_LINE_OE <= 1'b0;
          end
          if (tim_q == samp_at_q) begin
            samp_q <= I_LINE_I;
          end
          if (tim_q == end_q) begin
            sl_q  <= SL_REC;
            tim_q <= '0;
          end
        end
        SL_REC: begin
          tim_q <= tim_q + timer_t'(1);
          if (tim_q == RECOVERY_CYC - timer_t'(1)) begin
            sl_q   <= SL_IDLE;
            done_q <= 1'b1;
          end
        end
        default: begin
          sl_q      <= SL_IDLE;
          O_LINE_OE <= 1'b0;
        end
      endcase
    end
  end

  // Search direction: forced when bit and complement differ, else the user's choice
  assign srch_dir = (id_q != samp_q) ? id_q : dirsel_q;

  // Command sequencer
  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      sq_q        <= SQ_IDLE;
      O_CMD_READY <= 1'b0;
      O_BUSY      <= 1'b0;
      O_PRESENCE  <= 1'b0;
      start_q     <= 1'b0;
      kind_rst_q  <= 1'b0;
      wbit_q      <= 1'b1;
      op_q        <= OP_RESET;
      shift_q     <= 8'hFF;
      bitcnt_q    <= 3'h0;
      trip_q      <= 2'h0;
      id_q        <= 1'b0;
      cmp_q       <= 1'b0;
      dirsel_q    <= 1'b0;
      res_q       <= 8'h00;
    end else begin
      start_q <= 1'b0;
      unique case (sq_q)
        SQ_IDLE: begin
          O_CMD_READY <= 1'b1;
          O_BUSY      <= 1'b0;
          if (I_CMD_VALID && O_CMD_READY) begin
            O_CMD_READY <= 1'b0;
            O_BUSY      <= 1'b1;
            op_q        <= I_CMD.op;
            dirsel_q    <= I_CMD.dir;
            bitcnt_q    <= 3'h0;
            trip_q      <= 2'h0;
            start_q     <= 1'b1;
            // Reads send ones so the slave can pull the bit low
            shift_q     <= (I_CMD.op == OP_WRITE) ? I_CMD.data : 8'hFF;
            wbit_q      <= (I_CMD.op == OP_WRITE) ? I_CMD.data[0] : 1'b1;
            kind_rst_q  <= (I_CMD.op == OP_RESET);
            sq_q        <= (I_CMD.op == OP_RESET) ? SQ_RESET : SQ_BITS;
          end
        end
        SQ_RESET: begin
          if (done_q) begin
            O_PRESENCE <= !samp_q;
            sq_q       <= SQ_IDLE;
          end
        end
        SQ_BITS: begin
          if (done_q) begin
            if (op_q == OP_SEARCH) begin
              unique case (trip_q)
                2'h0: begin
                  id_q    <= samp_q;
                  trip_q  <= 2'h1;
                  wbit_q  <= 1'b1;
                  start_q <= 1'b1;
                end
                2'h1: begin
                  cmp_q <= samp_q;
                  if (id_q && samp_q) begin
                    // Nobody answered: skip the write slot
                    res_q <= {4'h0, 1'b1, 1'b1, samp_q, id_q};
                    sq_q  <= SQ_PUSH;
                  end else begin
                    trip_q  <= 2'h2;
                    wbit_q  <= srch_dir;
                    start_q <= 1'b1;
                    res_q   <= {4'h0, 1'b0, srch_dir, samp_q, id_q};
                  end
                end
                default: begin
                  sq_q <= SQ_PUSH;
                end
              endcase
            end else begin
              // Sampled level is the readback, also for writes on a wired-AND line
              shift_q <= {samp_q, shift_q[7:1]};
              if (bitcnt_q == 3'h7) begin
                res_q <= {samp_q, shift_q[7:1]};
                sq_q  <= (op_q == OP_READ) ? SQ_PUSH : SQ_IDLE;
              end else begin
                bitcnt_q <= bitcnt_q + 3'h1;
                wbit_q   <= (op_q == OP_WRITE) ? shift_q[1] : 1'b1;
                start_q  <= 1'b1;
              end
            end
          end
        end
        SQ_PUSH: begin
          // Full FIFO stalls the sequencer, so no result is dropped
          if (fifo_in_ready) begin
            sq_q <= SQ_IDLE;
          end
        end
        default: begin
          sq_q <= SQ_IDLE;
        end
      endcase
    end
  end

  assign push_valid = (sq_q == SQ_PUSH);

  // Every byte bit on the line feeds the CRC; the user judges the result
  assign crc_en = done_q && (sq_q == SQ_BITS) && (op_q != OP_SEARCH);

  swl_crc8 u_crc (
    .i_clk   (I_CORE_CLK),
    .i_rst_n (rst_n),
    .i_clr   (I_CRC_CLEAR),
    .i_en    (crc_en),
    .i_bit   (samp_q),
    .o_crc   (O_CRC)
  );

  swl_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (I_CORE_CLK),
    .i_rst_n     (rst_n),
    .i_in_valid  (push_valid),
    .i_in_data   (res_q),
    .o_in_ready  (fifo_in_ready),
    .o_out_valid (O_RD_VALID),
    .o_out_data  (O_RD_DATA),
    .i_out_ready (I_RD_READY)
  );

  // Unused search complement bit copy kept only for result layout
  logic unused_cmp;
  assign unused_cmp = cmp_q;
endmodule
`default_nettype wire

// [tb/swl_host_monitor.sv]
// Checker for the single-wire link master: line pulses, handshakes, CRC.
// Assumes it is bound to swl_host and the line has a pull-up.
`timescale 1ns/1ns
`default_nettype none
module swl_host_monitor
  import swl_host_pkg::*;
#(
  parameter timer_t RESET_LOW_CYC  = timer_t'(RESET_LOW_CYCLES),
  parameter timer_t WRITE_ZERO_CYC = timer_t'(WRITE_ZERO_CYCLES)
) (
  // Clock and reset
  input wire logic       I_CORE_CLK,
  input wire logic       I_ARST_N,
  // Command and read ports
  input wire logic       I_CMD_VALID,
  input wire cmd_t       I_CMD,
  input wire logic       O_CMD_READY,
  input wire logic       O_RD_VALID,
  input wire logic [7:0] O_RD_DATA,
  input wire logic       I_RD_READY,
  // Status and line
  input wire logic       I_CRC_CLEAR,
  input wire logic [7:0] O_CRC,
  input wire logic       O_PRESENCE,
  input wire logic       O_BUSY,
  input wire logic       I_LINE_I,
  input wire logic       O_LINE_O,
  input wire logic       O_LINE_OE
);
  localparam int RL = int'(RESET_LOW_CYC);
  localparam int WZ = int'(WRITE_ZERO_CYC);
  int low_run_q;
  int high_run_q;

  // Length of the current low pulse driven by the master
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) low_run_q <= 0;
    else low_run_q <= O_LINE_OE ? low_run_q + 1 : 0;
  end

  // Line high time; starts saturated so the first slot after reset passes
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) high_run_q <= 100_000;
    else if (!I_LINE_I) high_run_q <= 0;
    else if (high_run_q < 100_000) high_run_q <= high_run_q + 1;
  end

  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_ARST_N);

  chk_drive_only_low: assert property (O_LINE_O == 1'b0)
    else $error("line output driven high");
  chk_low_pulse_len: assert property ($fell(O_LINE_OE) |-> low_run_q inside
    {[WRITE_ONE_CYCLES:WRITE_ONE_CYCLES+1], [WZ:WZ+1], [RL:RL+1]})
    else $error("low pulse length wrong");
  chk_line_recovery: assert property ($rose(O_LINE_OE) |-> high_run_q >= RECOVERY_CYCLES)
    else $error("recovery before slot too short");
  chk_idle_line_free: assert property (O_CMD_READY |-> !O_LINE_OE)
    else $error("line held low while idle");
  chk_take_drops_ready: assert property (I_CMD_VALID && O_CMD_READY |=> !O_CMD_READY ##[0:2] O_BUSY)
    else $error("command take not seen");
  chk_crc_clear_zero: assert property (I_CRC_CLEAR |=> O_CRC == 8'h00)
    else $error("crc not cleared");
  chk_crc_quiet_idle: assert property (!O_BUSY && !I_CRC_CLEAR |=> $stable(O_CRC))
    else $error("crc moved while idle");
  chk_presence_in_cmd: assert property (!$stable(O_PRESENCE) |-> $past(O_BUSY))
    else $error("presence changed outside a reset");
  chk_read_hold: assert property (O_RD_VALID && !I_RD_READY |=> O_RD_VALID && $stable(O_RD_DATA))
    else $error("read data dropped under stall");
endmodule

bind swl_host swl_host_monitor #(.RESET_LOW_CYC(RESET_LOW_CYC), .WRITE_ZERO_CYC(WRITE_ZERO_CYC)) chk_u (
  .I_CORE_CLK(I_CORE_CLK), .I_ARST_N(I_ARST_N), .I_CMD_VALID(I_CMD_VALID), .I_CMD(I_CMD),
  .O_CMD_READY(O_CMD_READY), .O_RD_VALID(O_RD_VALID), .O_RD_DATA(O_RD_DATA), .I_RD_READY(I_RD_READY),
  .I_CRC_CLEAR(I_CRC_CLEAR), .O_CRC(O_CRC), .O_PRESENCE(O_PRESENCE), .O_BUSY(O_BUSY),
  .I_LINE_I(I_LINE_I), .O_LINE_O(O_LINE_O), .O_LINE_OE(O_LINE_OE));
`default_nettype wire

// [tb/swl_slave_model.sv]
// Behavioural slave on the single-wire link: identifier and its commands.
// Assumes the bench resolves the line as a wired-AND with a pull-up.
`timescale 1ns/1ns
`default_nettype none
module swl_slave_model #(
  parameter logic [7:0]  FAMILY_CODE = 8'h5A,           // Arbitrary value
  parameter logic [47:0] SERIAL      = 48'h3C1D_9E04_B7A2,
  parameter int          RST_DET     = 1460,
  parameter int          SAMPLE_AT   = 900,
  parameter int          DRIVE_END   = 1420,
  parameter int          PDH         = 10,
  parameter int          PDL         = 100
) (
  input  wire logic i_clk,
  input  wire logic i_line,
  output logic      o_pull
);
  logic [63:0] id;
  logic [7:0]  cmd;
  int          lowcnt = 0, t = -1, pres = 0, st = 0, idx = 0, ph = 0;
  logic        prev = 1'b1, pl = 1'b0, armed = 1'b0, sending = 1'b0, snd, bitv;

  // Family low, serial next, CRC of the first 56 bits on top
  initial begin
    logic [7:0]  c;
    logic [55:0] v;
    c = 8'h00;
    v = {SERIAL, FAMILY_CODE};
    for (int i = 0; i < 56; i++) c = {1'b0, c[7:1]} ^ ((c[0] ^ v[i]) ? 8'h8C : 8'h00);
    id = {c, v};
    o_pull = 1'b0;
  end

  // Written bit, taken in the sample window; no CRC is ever compared here
  task automatic take(input logic b);
    if (st == 1) begin
      cmd[idx] = b;
      idx++;
      if (idx == 8) begin
        idx = 0;
        ph = 0;
        case (cmd)
          8'h33: st = 2;
          8'h55: st = 4;
          8'hF0: st = 3;
          8'hCC: st = 5;
          default: st = 5;
        endcase
      end
    end else if ((st == 3 && ph == 2) || st == 4) begin
      if (b !== id[idx]) st = 0;
      else begin
        idx++;
        ph = 0;
        if (idx == 64) st = 5;
      end
    end
  endtask

  // Line watcher; pull changes land after the edge so the master sees them next cycle
  always @(posedge i_clk) begin
    snd = (st == 2) || (st == 3 && ph < 2);
    bitv = (st == 3 && ph == 1) ? ~id[idx] : id[idx];
    lowcnt = i_line ? 0 : lowcnt + 1;
    if (lowcnt == RST_DET) begin
      armed = 1'b1;
      st = 1;
      idx = 0;
      t = -1;
      pl = 1'b0;
    end
    if (i_line && !prev && armed) begin
      armed = 1'b0;
      pres = PDH + PDL;
    end
    if (pres > 0) begin
      pres--;
      pl = (pres > 0) && (pres <= PDL);
    end else if (prev && !i_line && st != 0) begin
      t = 0;
      // Slot kind is latched here; a command byte that ends mid-slot must not advance the bit index
      sending = snd;
      pl = snd && !bitv;
    end else if (t >= 0) begin
      t++;
      if (t == SAMPLE_AT && !sending) take(i_line);
      if (t == DRIVE_END) begin
        pl = 1'b0;
        t = -1;
        if (sending) begin
          if (st == 2) begin
            idx++;
            if (idx == 64) st = 5;
          end else begin
            ph++;
          end
        end
      end
    end
    prev = i_line;
    o_pull <= pl;
  end
endmodule
`default_nettype wire

// [tb/swl_host_tb.sv]
// Bench for the single-wire link master with a behavioural slave on the line.
// Assumes shortened reset and slot counts; expected values come from an id model.
`timescale 1ns/1ns
`default_nettype none
module swl_host_tb;
  import swl_host_pkg::*;
  logic       I_CORE_CLK = 0, I_ARST_N = 0, I_CMD_VALID = 0, I_RD_READY = 0, I_CRC_CLEAR = 0;
  cmd_t       I_CMD = '0;
  logic       O_CMD_READY, O_RD_VALID, O_PRESENCE, O_BUSY, O_LINE_O, O_LINE_OE, slave_pull;
  logic [7:0] O_RD_DATA, O_CRC, crc_m;
  wire        line;
  int         err_total = 0, samples_checked = 0, seed = 51250;
  logic [7:0] exp_q[$];
  logic [63:0] id;
  logic        b;

  // Wired-AND with pull-up: low if either side pulls
  assign line = ~(O_LINE_OE | slave_pull);
  always #5 I_CORE_CLK = ~I_CORE_CLK;

  swl_host #(.RESET_LOW_CYC(20'd1500), .PRES_SAMPLE_CYC(20'd40), .RESET_HIGH_CYC(20'd200),
    .SLOT_CYC(20'd1600), .WRITE_ZERO_CYC(20'd1400)) dut_u (
    .I_CORE_CLK(I_CORE_CLK), .I_ARST_N(I_ARST_N), .I_CMD_VALID(I_CMD_VALID), .I_CMD(I_CMD),
    .O_CMD_READY(O_CMD_READY), .O_RD_VALID(O_RD_VALID), .O_RD_DATA(O_RD_DATA), .I_RD_READY(I_RD_READY),
    .I_CRC_CLEAR(I_CRC_CLEAR), .O_CRC(O_CRC), .O_PRESENCE(O_PRESENCE), .O_BUSY(O_BUSY),
    .I_LINE_I(line), .O_LINE_O(O_LINE_O), .O_LINE_OE(O_LINE_OE));
  swl_slave_model slave_u (.i_clk(I_CORE_CLK), .i_line(line), .o_pull(slave_pull));

  // Reflected CRC step, one bit, least significant first
  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic d);
    crc_step = {1'b0, c[7:1]} ^ ((c[0] ^ d) ? 8'h8C : 8'h00);
  endfunction

  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Wait until the command port is free; a hang counts as a mismatch
  task automatic wait_ready;
    int n;
    n = 0;
    while (O_CMD_READY !== 1'b1 && n < 40000) begin
      @(negedge I_CORE_CLK);
      n++;
    end
    if (n == 40000) check8(8'h00, 8'h01, "ready timeout");
  endtask

  // Held until taken at the rising edge that sees ready high
  task automatic issue(input op_t op, input logic [7:0] d, input logic dr);
    @(negedge I_CORE_CLK);
    I_CMD_VALID = 1'b1;
    I_CMD = '{op: op, data: d, dir: dr};
    wait_ready;
    @(negedge I_CORE_CLK);
    I_CMD_VALID = 1'b0;
  endtask

  // Pop results with random stalls; ready stays low for at least one edge between pops
  task automatic drain(input int cnt, input string what);
    int n;
    repeat (cnt) begin
      n = 0;
      do begin
        @(negedge I_CORE_CLK);
        n++;
      end while (!(O_RD_VALID === 1'b1 && ($random(seed) & 1)) && n < 40000);
      check8(O_RD_DATA, exp_q.pop_front(), what);
      I_RD_READY = 1'b1;
      @(negedge I_CORE_CLK);
      I_RD_READY = 1'b0;
    end
  endtask

  initial begin
    // About 91k cycles of slots are expected; a hang is cut off just above that
    #950_000;
    err_total++;
    $display("BAD t=%0t watchdog expired", $time);
    test_done;
  end

  initial begin
    repeat (6) @(negedge I_CORE_CLK);
    I_ARST_N = 1'b1;
    id = slave_u.id;
    crc_m = 8'h00;
    for (int i = 0; i < 56; i++) crc_m = crc_step(crc_m, id[i]);
    check8(id[63:56], crc_m, "id crc byte");
    // Reset pulse answered by presence
    issue(OP_RESET, 8'h00, 1'b0);
    wait_ready;
    check8({7'h00, O_PRESENCE}, 8'h01, "presence");
    $display("test reset done");
    // Read identifier: two bytes held in the buffer, then drained
    issue(OP_WRITE, CMD_READ_ID, 1'b0);
    wait_ready;
    @(negedge I_CORE_CLK);
    I_CRC_CLEAR = 1'b1;
    @(negedge I_CORE_CLK);
    I_CRC_CLEAR = 1'b0;
    issue(OP_READ, 8'h00, 1'b0);
    issue(OP_READ, 8'h00, 1'b0);
    wait_ready;
    exp_q.push_back(id[7:0]);
    exp_q.push_back(id[15:8]);
    drain(2, "id byte");
    crc_m = 8'h00;
    for (int i = 0; i < 16; i++) crc_m = crc_step(crc_m, id[i]);
    check8(O_CRC, crc_m, "running crc");
    $display("test read id done");
    // Search: single slave gives bit and complement, master follows the bit
    issue(OP_RESET, 8'h00, 1'b0);
    issue(OP_WRITE, CMD_SEARCH_ID, 1'b0);
    for (int k = 0; k < 3; k++) begin
      b = id[k];
      issue(OP_SEARCH, 8'h00, 1'($random(seed)));
      exp_q.push_back({4'h0, 1'b0, b, ~b, b});
    end
    wait_ready;
    drain(3, "search triplet");
    check8({7'h00, O_PRESENCE}, 8'h01, "presence kept");
    $display("test search done");
    test_done;
  end
endmodule
`default_nettype wire
